// ===== common/tpi_pkg.sv
// Shared constants and types for the eight-bit timer with shared prescaler
package tpi_pkg;

  // Register bus geometry
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned DATA_W     = 32;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG  = 8'h00;  // Ratio, assignment, counter mode
  localparam logic [7:0] ADDR_COUNT   = 8'h04;  // Eight-bit count register
  localparam logic [7:0] ADDR_STATUS  = 8'h08;  // Sticky overflow flag, write one clears
  localparam logic [7:0] ADDR_MASK    = 8'h0c;  // Overflow interrupt enable
  localparam logic [7:0] ADDR_COMMAND = 8'h10;  // Clear-watchdog command, reads zero

  // Field layout
  localparam int unsigned RATIO_W     = 3;  // Prescale ratio field width
  localparam int unsigned RATIO_LSB   = 0;
  localparam int unsigned ASSIGN_BIT  = 3;  // 0 = timer, 1 = watchdog
  localparam int unsigned CNTMODE_BIT = 4;  // 1 = count external input edges
  localparam int unsigned CONFIG_W    = 5;
  localparam int unsigned FLAG_BIT    = 0;
  localparam int unsigned IRQEN_BIT   = 0;
  localparam int unsigned CLEAR_WATCHDOG_INSTRUCTION_BIT  = 0;

  // Widths of the counters
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned PS_W    = 8;  // Deepest tap gives divide-by-256

  // Reset values
  localparam logic [CONFIG_W-1:0] CONFIG_RESET = 5'h0f;  // Prescaler on watchdog, max ratio
  localparam logic [COUNT_W-1:0]  COUNT_RESET  = 8'h00;
  localparam logic [COUNT_W-1:0]  COUNT_MAX    = 8'hff;
  localparam logic [PS_W-1:0]     PS_RESET     = 8'h00;

  // Instruction cycle phases, four clocks per instruction cycle
  localparam logic [1:0] PHASE_Q2   = 2'h1;
  localparam logic [1:0] PHASE_LAST = 2'h3;  // Q4

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus channel states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } tpi_bus_state_t;

endpackage : tpi_pkg

// ===== common/tpi_reg_if.sv
// Register access carrier between the bus slave and the timer core
`timescale 1ns/1ps
interface tpi_reg_if;
  logic        wr_en;    // One-cycle write strobe
  logic [7:0]  wr_addr;  // Write byte address
  logic [31:0] wr_data;  // Write data
  logic [3:0]  wr_strb;  // Write byte enables
  logic        wr_hit;   // Write address is mapped
  logic [7:0]  rd_addr;  // Read byte address
  logic [31:0] rd_data;  // Read data for rd_addr
  logic        rd_hit;   // Read address is mapped

  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input  wr_hit, rd_data, rd_hit);
  modport regs  (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface : tpi_reg_if

// ===== core/tpi_axil_slave.sv
// AXI4-Lite slave front end for the timer registers
`timescale 1ns/1ps
module tpi_axil_slave (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  tpi_reg_if.slave         regs
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  tpi_pkg::tpi_bus_state_t wr_state, next_wr_state;  // Write channel phase
  tpi_pkg::tpi_bus_state_t rd_state, next_rd_state;  // Read channel phase
  logic                    aw_got, next_aw_got;      // Address captured
  logic                    w_got, next_w_got;        // Data captured
  logic [7:0]              aw_addr, next_aw_addr;
  logic [31:0]             w_data, next_w_data;
  logic [3:0]              w_strb, next_w_strb;
  logic [1:0]              next_bresp;
  logic [31:0]             next_rdata;
  logic [1:0]              next_rresp;
  logic                    wr_fire;                  // Both halves present

  // Ready while idle and that half not yet held; order of arrival is free
  assign awready = (wr_state == tpi_pkg::BUS_IDLE) && !aw_got;
  assign wready  = (wr_state == tpi_pkg::BUS_IDLE) && !w_got;
  assign bvalid  = (wr_state == tpi_pkg::BUS_RESP);
  assign arready = (rd_state == tpi_pkg::BUS_IDLE);
  assign rvalid  = (rd_state == tpi_pkg::BUS_RESP);

  // Write goes out in the first cycle that both halves are held
  assign wr_fire       = (wr_state == tpi_pkg::BUS_IDLE) && aw_got && w_got;
  assign regs.wr_en    = wr_fire;
  assign regs.wr_addr  = aw_addr;
  assign regs.wr_data  = w_data;
  assign regs.wr_strb  = w_strb;
  assign regs.rd_addr  = araddr;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for both channels
  always_comb begin
    next_wr_state = wr_state;
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bresp    = bresp;
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    // Capture each half as it is offered
    if (awvalid && awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_got  = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    case (wr_state)
      tpi_pkg::BUS_IDLE: begin
        if (wr_fire) begin
          next_wr_state = tpi_pkg::BUS_RESP;
          next_aw_got   = 1'b0;
          next_w_got    = 1'b0;
          next_bresp    = regs.wr_hit ? tpi_pkg::RESP_OKAY : tpi_pkg::RESP_SLVERR;
        end
      end
      tpi_pkg::BUS_RESP: begin
        if (bready) begin
          next_wr_state = tpi_pkg::BUS_IDLE;
        end
      end
      default: next_wr_state = tpi_pkg::BUS_IDLE;
    endcase
    case (rd_state)
      tpi_pkg::BUS_IDLE: begin
        // Data is sampled at acceptance so it is stable while rvalid stands
        if (arvalid) begin
          next_rd_state = tpi_pkg::BUS_RESP;
          next_rdata    = regs.rd_data;
          next_rresp    = regs.rd_hit ? tpi_pkg::RESP_OKAY : tpi_pkg::RESP_SLVERR;
        end
      end
      tpi_pkg::BUS_RESP: begin
        if (rready) begin
          next_rd_state = tpi_pkg::BUS_IDLE;
        end
      end
      default: next_rd_state = tpi_pkg::BUS_IDLE;
    endcase
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_state <= tpi_pkg::BUS_IDLE;
      rd_state <= tpi_pkg::BUS_IDLE;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      bresp    <= tpi_pkg::RESP_OKAY;
      rdata    <= 32'h0000_0000;
      rresp    <= tpi_pkg::RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_got   <= next_aw_got;
      w_got    <= next_w_got;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bresp    <= next_bresp;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

endmodule : tpi_axil_slave

// ===== core/tpi_timer_top.sv
// Eight-bit timer with a prescaler shared with the watchdog
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tpi_timer_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        timer_ext_clock_in,  // External count input
  input  wire logic        sleep_mode,          // Processor asleep
  input  wire logic        wdt_osc_tick,        // Watchdog oscillator tick
  output logic             wdt_prescaled_tick,  // Tick toward watchdog counter
  output logic             wdt_clear,           // Clear pulse toward watchdog
  output logic             irq                  // Timer overflow interrupt
);

  localparam int unsigned PW = tpi_pkg::PS_W;
  localparam int unsigned CW = tpi_pkg::COUNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  tpi_reg_if regs ();

  tpi_axil_slave u_slave (
    .mclk    (mclk),
    .reset   (reset),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (regs.slave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [tpi_pkg::CONFIG_W-1:0] config_reg, next_config_reg;  // Control bits
  logic [CW-1:0]                timer_count_reg, next_count;   // Count register
  logic                         timer_overflow_flag, next_flag;
  logic                         timer_overflow_irq_en, next_irq_en;
  logic [PW-1:0]                ps_cnt, next_ps_cnt;           // Shared prescaler
  logic [1:0]                   q_phase, next_q_phase;         // Instruction phase
  logic                         ext_prev, next_ext_prev;       // Edge detect on pin
  logic                         samp_q2, next_samp_q2;         // Q2 sample
  logic                         samp_q4, next_samp_q4;         // Q4 sample
  logic                         samp_q4_d, next_samp_q4_d;     // Q4 sample delayed
  logic                         next_wdt_tick;
  logic                         next_wdt_clear;

  // Decoded control bits
  logic [tpi_pkg::RATIO_W-1:0] prescale_ratio_field;
  logic                        prescaler_assign_sel;
  logic                        counter_mode;
  assign prescale_ratio_field = config_reg[tpi_pkg::RATIO_LSB +: tpi_pkg::RATIO_W];
  assign prescaler_assign_sel = config_reg[tpi_pkg::ASSIGN_BIT];
  assign counter_mode         = config_reg[tpi_pkg::CNTMODE_BIT];

  // Write decode, byte lane zero carries every field
  logic lane0;
  logic wr_config, wr_count, wr_status, wr_mask, wr_cmd;
  logic clear_watchdog_instruction;  // One-cycle command strobe
  assign lane0     = regs.wr_en && regs.wr_strb[0];
  assign wr_config = lane0 && (regs.wr_addr == tpi_pkg::ADDR_CONFIG);
  assign wr_count  = lane0 && (regs.wr_addr == tpi_pkg::ADDR_COUNT);
  assign wr_status = lane0 && (regs.wr_addr == tpi_pkg::ADDR_STATUS);
  assign wr_mask   = lane0 && (regs.wr_addr == tpi_pkg::ADDR_MASK);
  assign wr_cmd    = lane0 && (regs.wr_addr == tpi_pkg::ADDR_COMMAND);
  assign clear_watchdog_instruction = wr_cmd && regs.wr_data[tpi_pkg::CLEAR_WATCHDOG_INSTRUCTION_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Input pulse selection
  logic run;        // Timer runs only while awake
  logic q2_en;      // Q2 phase enable
  logic q4_en;      // Q4 phase enable
  logic src_pulse;  // Timer input event
  logic ps_in;      // Prescaler input event
  assign run       = !sleep_mode;
  assign q2_en     = (q_phase == tpi_pkg::PHASE_Q2);
  assign q4_en     = (q_phase == tpi_pkg::PHASE_LAST);
  assign src_pulse = run && (counter_mode ? (timer_ext_clock_in && !ext_prev) : q4_en);
  // Single prescaler, input steered by the assignment bit
  assign ps_in     = prescaler_assign_sel ? wdt_osc_tick : src_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Tap ticks: tap k fires once per 2^k input events
  logic [PW:0] carry;  // All lower bits ones while input fires
  logic [PW:0] tap;    // Rising edge of each prescaler bit
  assign carry[0] = ps_in;
  assign tap[0]   = ps_in;
  genvar k;
  generate
    for (k = 0; k < PW; k++) begin : g_tap
      assign carry[k+1] = carry[k] && ps_cnt[k];
      assign tap[k+1]   = carry[k] && !ps_cnt[k];
    end
  endgenerate

  // Timer takes tap n+1, watchdog tap n
  logic tmr_ps_tick;
  logic wdt_tap;
  assign tmr_ps_tick = !prescaler_assign_sel && tap[prescale_ratio_field + 4'h1];
  assign wdt_tap     = prescaler_assign_sel && tap[prescale_ratio_field];

  // Level seen by the counter-mode sampler: prescaler bit or raw pin
  logic samp_src;
  assign samp_src = prescaler_assign_sel ? timer_ext_clock_in
                                         : ps_cnt[prescale_ratio_field];

  // Count event; in timer mode, bypass gives one step per instruction cycle
  logic tmr_inc;
  always_comb begin
    if (!run) begin
      tmr_inc = 1'b0;
    end else if (counter_mode) begin
      tmr_inc = samp_q4 && !samp_q4_d;
    end else if (prescaler_assign_sel) begin
      tmr_inc = q4_en;
    end else begin
      tmr_inc = tmr_ps_tick;
    end
  end

  // Wrap from the maximum count; a same-cycle write wins over the step
  logic wrap;
  assign wrap = tmr_inc && !wr_count && (timer_count_reg == tpi_pkg::COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    next_config_reg = config_reg;
    next_irq_en     = timer_overflow_irq_en;
    next_q_phase    = q_phase + 2'h1;
    next_ext_prev   = timer_ext_clock_in;
    next_samp_q2    = q2_en ? samp_src : samp_q2;
    next_samp_q4    = q4_en ? samp_q2 : samp_q4;
    next_samp_q4_d  = samp_q4;
    next_wdt_tick   = wdt_tap;
    next_wdt_clear  = clear_watchdog_instruction;
    // Control bits; ordering of moves between timer and watchdog is software's
    if (wr_config) begin
      next_config_reg = regs.wr_data[tpi_pkg::CONFIG_W-1:0];
    end
    if (wr_mask) begin
      next_irq_en = regs.wr_data[tpi_pkg::IRQEN_BIT];
    end
    // Prescaler clears depend on which side owns it
    if ((wr_count && !prescaler_assign_sel) ||
        (clear_watchdog_instruction && prescaler_assign_sel)) begin
      next_ps_cnt = tpi_pkg::PS_RESET;
    end else if (ps_in) begin
      next_ps_cnt = ps_cnt + PW'(1);
    end else begin
      next_ps_cnt = ps_cnt;
    end
    // Count register: write beats increment
    if (wr_count) begin
      next_count = regs.wr_data[CW-1:0];
    end else if (tmr_inc) begin
      next_count = timer_count_reg + CW'(1);
    end else begin
      next_count = timer_count_reg;
    end
    // Sticky flag: a wrap in the clearing cycle is kept
    if (wrap) begin
      next_flag = 1'b1;
    end else if (wr_status && regs.wr_data[tpi_pkg::FLAG_BIT]) begin
      next_flag = 1'b0;
    end else begin
      next_flag = timer_overflow_flag;
    end
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      config_reg            <= tpi_pkg::CONFIG_RESET;
      timer_count_reg       <= tpi_pkg::COUNT_RESET;
      timer_overflow_flag   <= 1'b0;
      timer_overflow_irq_en <= 1'b0;
      ps_cnt                <= tpi_pkg::PS_RESET;
      q_phase               <= 2'h0;
      ext_prev              <= 1'b0;
      samp_q2               <= 1'b0;
      samp_q4               <= 1'b0;
      samp_q4_d             <= 1'b0;
      wdt_prescaled_tick    <= 1'b0;
      wdt_clear             <= 1'b0;
    end else begin
      config_reg            <= next_config_reg;
      timer_count_reg       <= next_count;
      timer_overflow_flag   <= next_flag;
      timer_overflow_irq_en <= next_irq_en;
      ps_cnt                <= next_ps_cnt;
      q_phase               <= next_q_phase;
      ext_prev              <= next_ext_prev;
      samp_q2               <= next_samp_q2;
      samp_q4               <= next_samp_q4;
      samp_q4_d             <= next_samp_q4_d;
      wdt_prescaled_tick    <= next_wdt_tick;
      wdt_clear             <= next_wdt_clear;
    end
  end

  // Request leaves only while enabled
  assign irq = timer_overflow_flag && timer_overflow_irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // Register read and decode; the prescaler count has no address
  always_comb begin
    regs.rd_data = 32'h0000_0000;
    regs.rd_hit  = 1'b1;
    case (regs.rd_addr)
      tpi_pkg::ADDR_CONFIG:  regs.rd_data[tpi_pkg::CONFIG_W-1:0] = config_reg;
      tpi_pkg::ADDR_COUNT:   regs.rd_data[CW-1:0] = timer_count_reg;
      tpi_pkg::ADDR_STATUS:  regs.rd_data[tpi_pkg::FLAG_BIT] = timer_overflow_flag;
      tpi_pkg::ADDR_MASK:    regs.rd_data[tpi_pkg::IRQEN_BIT] = timer_overflow_irq_en;
      tpi_pkg::ADDR_COMMAND: regs.rd_data = 32'h0000_0000;
      default:               regs.rd_hit = 1'b0;
    endcase
  end

  assign regs.wr_hit = (regs.wr_addr == tpi_pkg::ADDR_CONFIG) ||
                       (regs.wr_addr == tpi_pkg::ADDR_COUNT)  ||
                       (regs.wr_addr == tpi_pkg::ADDR_STATUS) ||
                       (regs.wr_addr == tpi_pkg::ADDR_MASK)   ||
                       (regs.wr_addr == tpi_pkg::ADDR_COMMAND);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [PW-1:0] ps_mask;  // Bits at and below the selected ratio
  assign ps_mask = ~({PW{1'b1}} << ({1'b0, prescale_ratio_field} + 4'h1));

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_single_route: assert property (
    !(tmr_ps_tick && wdt_tap)) else $error("prescaler feeds both sides");
  chk_assign_route: assert property (
    wdt_prescaled_tick |-> ($past(prescaler_assign_sel) && $past(wdt_osc_tick)))
    else $error("watchdog tick while timer owns");
  chk_ratio_span: assert property (
    tmr_ps_tick |-> ((ps_cnt & ps_mask) == (ps_mask >> 1)))
    else $error("timer tick at wrong prescaler count");
  chk_bypass_rate: assert property (
    (prescaler_assign_sel && !counter_mode && q4_en && run) |-> tmr_inc)
    else $error("bypass missed an instruction cycle");
  chk_write_clears: assert property (
    (wr_count && !prescaler_assign_sel) |=> (ps_cnt == tpi_pkg::PS_RESET))
    else $error("count write left prescaler");
  chk_clear_watchdog_instruction_clears: assert property (
    (clear_watchdog_instruction && prescaler_assign_sel) |=>
      (ps_cnt == tpi_pkg::PS_RESET) && wdt_clear)
    else $error("clear-watchdog left prescaler");
  chk_wrap_flag: assert property (
    wrap |=> timer_overflow_flag && (timer_count_reg == tpi_pkg::COUNT_RESET))
    else $error("wrap did not set flag");
  chk_flag_hold: assert property (
    (timer_overflow_flag && !wr_status) |=> timer_overflow_flag)
    else $error("flag cleared without software");
  chk_irq_gate: assert property (
    irq |-> timer_overflow_irq_en && timer_overflow_flag)
    else $error("interrupt without enable");
  chk_sleep_freeze: assert property (
    (sleep_mode && !wr_count) |=> $stable(timer_count_reg))
    else $error("count moved in sleep");
  chk_q_sample: assert property (
    ($changed(samp_q4) || $changed(samp_q2)) |-> ($past(q4_en) || $past(q2_en)))
    else $error("sample off Q2 or Q4");
  chk_count_step: assert property (
    (tmr_inc && !wr_count) |=> (timer_count_reg == $past(timer_count_reg) + CW'(1)))
    else $error("count did not step by one");

endmodule : tpi_timer_top

// ===== bench/tb_tpi_timer_top.sv
// Self-checking bench for the eight-bit timer with shared prescaler
`timescale 1ns/1ps
module tb_tpi_timer_top;
  logic mclk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, bs;
  logic awready, wready, bvalid, arready, rvalid;
  logic pin, sleep_mode, osc, wtick, wclr, irq;
  int n_fail, tests_run, cyc, n_wt, n_wc;
  // Reset-value rows: address, expected data, expected response
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rv [6] = '{32'h0f, 0, 0, 0, 0, 0};
  logic [1:0] rr [6] = '{0, 0, 0, 0, 0, 2};
  tpi_timer_top u_tpi_timer_top (.mclk(mclk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_ext_clock_in(pin), .sleep_mode(sleep_mode),
    .wdt_osc_tick(osc), .wdt_prescaled_tick(wtick), .wdt_clear(wclr), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  // Clock; timeout and pulse counters
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    n_wt += wtick;
    n_wc += wclr;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // Bus tasks: each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!(bvalid && bready));
    // Ready stays high between transfers, so back-to-back calls never re-drive it
    bs = bresp;
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    araddr <= a; arvalid <= 1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!(rvalid && rready));
    rd = rdata; rs = rresp;
  endtask : rdw
  // Count read back lands within one step of the ideal
  task automatic near(input string nm, input int e);
    rdw(8'h04);
    check(nm, 32'(rd >= e - 1 && rd <= e + 1), 1);
  endtask : near
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, arvalid, pin, sleep_mode, osc} = 0;
    bready = 1;
    rready = 1;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; reset = 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    foreach (ra[i]) begin
      rdw(ra[i]);
      check("reg", rd, rv[i]);
      check("resp", 32'(rs), 32'(rr[i]));
    end
    // Prescaler count has no address: a write there is refused
    wr(8'h14, 32'hff);
    check("wresp", 32'(bs), 32'h2);
    // Bypass when on watchdog: one step per instruction cycle
    wr(8'h00, 32'h08); wr(8'h04, 0); repeat (40) @(posedge mclk);
    near("bypass", 11);
    // Timer-assigned ratio field 0 and 2
    wr(8'h00, 32'h00); wr(8'h04, 0); repeat (80) @(posedge mclk);
    near("div2", 10);
    wr(8'h00, 32'h02); wr(8'h04, 0); repeat (320) @(posedge mclk);
    near("div8", 10);
    // Wrap raises flag; enable gates irq; write one clears
    wr(8'h00, 32'h08); wr(8'h04, 32'hfe); repeat (20) @(posedge mclk);
    rdw(8'h08); check("flag", rd, 1);
    check("irq off", irq, 0);
    wr(8'h0c, 1); check("irq on", irq, 1);
    wr(8'h08, 1); rdw(8'h08); check("flag clr", rd, 0);
    check("irq clr", irq, 0);
    // Sleep freezes count
    sleep_mode <= 1; wr(8'h04, 5); repeat (60) @(posedge mclk);
    rdw(8'h04); check("sleep", rd, 5);
    sleep_mode <= 0;
    // Counter mode, bypassed: one step per pin rising edge
    wr(8'h00, 32'h18); wr(8'h04, 0);
    repeat (10) begin
      pin <= 1; repeat (8) @(posedge mclk);
      pin <= 0; repeat (8) @(posedge mclk);
    end
    rdw(8'h04); check("pin", rd, 10);
    // Counter mode through the prescaler, divide by 2 of pin edges
    wr(8'h00, 32'h10);
    wr(8'h04, 0);
    // Let the samplers drain any stale prescaler level before the real start
    repeat (12) @(posedge mclk);
    wr(8'h04, 0);
    repeat (20) begin
      pin <= 1;
      repeat (8) @(posedge mclk);
      pin <= 0;
      repeat (8) @(posedge mclk);
    end
    rdw(8'h04);
    check("pin div2", rd, 10);
    // Watchdog prescale divide by 4 after a clear
    wr(8'h00, 32'h0a); n_wc = 0; wr(8'h10, 1); repeat (3) @(posedge mclk);
    check("wclr", n_wc, 1);
    n_wt = 0;
    repeat (16) begin
      osc <= 1; @(posedge mclk);
      osc <= 0; @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    check("wdt div", n_wt, 4);
    // Watchdog to timer: clear first, then both fields in one write
    wr(8'h10, 1);
    wr(8'h00, 32'h03);
    rdw(8'h00);
    check("to tmr", rd, 32'h03);
    wr(8'h04, 0);
    repeat (640) @(posedge mclk);
    near("div16", 10);
    // Timer to watchdog: clear, zero count, select, clear, then ratio
    wr(8'h10, 1);
    wr(8'h04, 0);
    wr(8'h00, 32'h08);
    wr(8'h10, 1);
    wr(8'h00, 32'h0d);
    rdw(8'h00);
    check("to wdt", rd, 32'h0d);
    summarize();
  end
endmodule : tb_tpi_timer_top
